// ### include/pcm_port_pkg.sv
// Purpose: Shared constants for the PCM serial port and mode control.
// Assumes: All pins are asynchronous to the core clock.
// Notes: Register data is 8 bits wide; unused status bits read as zero, unused control bits read back as written.
// Overview of operation
// - Reset-powerdown low: power-down, control registers cleared.
// - Reset-powerdown request is pin OR control 0 bit 5.
// - Powerdown-hold low: power-down, all state kept.
// - Powerdown-hold request is pin OR control 0 bit 6.
// - Master clock is asynchronous to bit clocks and syncs.
// - Outputs send 8 bits MSB first on rising bit clock.
// - Outputs driven only in their word slot, else floating.
// - Through mode outputs carry 4 bits from the routed input.
// - Outputs float in power-down and initial mode.
// - Inputs sampled on falling bit clock, MSB first.
// - Frame sync rising edge marks the word MSB.
// - Through mode inputs take 4 bits, forwarded per routing.
// - Routing picks ADPCM or PCM timing for the secondary pair.
// - Routing picks the echo signal on the echo port.
// - Routing pins ORed with control 3 bits 6 and 5.
// - Through mode select puts the whole circuit in through mode.
package pcm_port_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [ADDR_W-1:0] CTRL0_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CTRL1_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] CTRL3_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    // Field positions
    localparam int CTRL0_RUN_BIT = 0;
    localparam int CTRL0_RESET_PD_BIT = 5;
    localparam int CTRL0_PD_HOLD_BIT = 6;
    localparam int CTRL1_THROUGH_BIT = 5;
    localparam int CTRL3_ROUTE_LO_BIT = 5;
    localparam int CTRL3_ROUTE_HI_BIT = 6;
    localparam int ST_RESET_PD_BIT = 0;
    localparam int ST_PD_HOLD_BIT = 1;
    localparam int ST_INIT_BIT = 2;
    localparam int ST_THROUGH_BIT = 3;
    localparam int ST_ROUTE_LO_BIT = 4;
    localparam int ST_ROUTE_HI_BIT = 5;
    localparam int ST_RANGE_BIT = 6;
    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    // Word lengths
    localparam int WORD_BITS = 8;
    localparam int THROUGH_BITS = 4;
    localparam int CNT_W = 4;
    // Pin vector layout
    localparam int PIN_COUNT = 13;
    localparam int P_RPD_N = 0;
    localparam int P_HOLD_N = 1;
    localparam int P_RANGE = 2;
    localparam int P_SKIP = 3;
    localparam int P_THRU = 4;
    localparam int P_ROUTE0 = 5;
    localparam int P_ROUTE1 = 6;
    localparam int P_PBCLK = 7;
    localparam int P_PSYNC = 8;
    localparam int P_ABCLK = 9;
    localparam int P_ASYNC = 10;
    localparam int P_ECHO_IN = 11;
    localparam int P_SEC_IN = 12;
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 13'h0003;
endpackage

// ### core/pcm_serial_lane.sv
// Purpose: Framed shifter for one PCM port pair.
// Assumes: Inputs already synchronised to the core clock.
// Notes: Mode is latched at each word start so a word is never split.
`timescale 1ns/100ps
`default_nettype none
module pcm_serial_lane
    import pcm_port_pkg::*;
#(
    parameter int WORD_LEN = WORD_BITS,
    parameter int THRU_LEN = THROUGH_BITS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic bclk_rise_i,
    input wire logic bclk_fall_i,
    input wire logic sync_i,
    input wire logic ser_in_i,
    input wire logic hold_i,
    input wire logic through_i,
    input wire logic [WORD_LEN-1:0] tx_word_i,
    input wire logic [THRU_LEN-1:0] thru_nibble_i,
    output logic ser_out_o,
    output logic ser_oe_o,
    output logic [WORD_LEN-1:0] rx_word_o,
    output logic rx_valid_o
);
    initial begin
        if (THRU_LEN > WORD_LEN || WORD_LEN >= (1 << CNT_W)) begin
            $error("bad word lengths");
        end
    end

    logic sync_prev_reg;
    logic thru_reg;
    logic [CNT_W-1:0] tx_cnt_reg;
    logic [CNT_W-1:0] rx_cnt_reg;
    logic [WORD_LEN-1:0] tx_shift_reg;
    logic [WORD_LEN-1:0] rx_shift_reg;
    logic [CNT_W-1:0] len;
    logic start;

    // Length follows the mode latched at word start
    assign len = thru_reg ? CNT_W'(THRU_LEN) : CNT_W'(WORD_LEN);
    assign start = bclk_rise_i && sync_i && !sync_prev_reg;

    // Transmit: launch on rising bit clock, MSB first
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_prev_reg <= 1'b0;
            thru_reg <= 1'b0;
            tx_cnt_reg <= CNT_W'(WORD_LEN);
            tx_shift_reg <= '0;
            ser_out_o <= 1'b0;
            ser_oe_o <= 1'b0;
        end else if (!hold_i && bclk_rise_i) begin
            sync_prev_reg <= sync_i;
            if (start) begin
                thru_reg <= through_i;
                if (through_i) begin
                    ser_out_o <= thru_nibble_i[THRU_LEN-1];
                    tx_shift_reg <= {thru_nibble_i[THRU_LEN-2:0],
                        {(WORD_LEN-THRU_LEN+1){1'b0}}};
                end else begin
                    ser_out_o <= tx_word_i[WORD_LEN-1];
                    tx_shift_reg <= {tx_word_i[WORD_LEN-2:0], 1'b0};
                end
                tx_cnt_reg <= CNT_W'(1);
                ser_oe_o <= 1'b1;
            end else if (tx_cnt_reg < len) begin
                ser_out_o <= tx_shift_reg[WORD_LEN-1];
                tx_shift_reg <= {tx_shift_reg[WORD_LEN-2:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg + CNT_W'(1);
            end else begin
                ser_oe_o <= 1'b0;
            end
        end
    end

    // Receive: sample on falling bit clock
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_cnt_reg <= CNT_W'(WORD_LEN);
            rx_shift_reg <= '0;
            rx_word_o <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (!hold_i && start) begin
                rx_cnt_reg <= '0;
            end else if (!hold_i && bclk_fall_i && rx_cnt_reg < len) begin
                rx_shift_reg <= {rx_shift_reg[WORD_LEN-2:0], ser_in_i};
                rx_cnt_reg <= rx_cnt_reg + CNT_W'(1);
                if (rx_cnt_reg + CNT_W'(1) == len) begin
                    rx_valid_o <= 1'b1;
                    // Through words left aligned
                    if (thru_reg) begin
                        rx_word_o <= {rx_shift_reg[THRU_LEN-2:0], ser_in_i,
                            {(WORD_LEN-THRU_LEN){1'b0}}};
                    end else begin
                        rx_word_o <= {rx_shift_reg[WORD_LEN-2:0], ser_in_i};
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### core/pcm_serial_port_power_ctrl.sv
// Purpose: PCM port pairs with power and mode control.
// Assumes: Master clock, asynchronous to all pins.
// Notes: Data and enable are separate; the pad resolves them.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pcm_serial_port_power_ctrl
    import pcm_port_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // Mode pins
    input wire logic reset_powerdown_in_n_i,
    input wire logic powerdown_hold_in_n_i,
    input wire logic master_clk_range_sel_i,
    input wire logic init_skip_i,
    input wire logic through_mode_sel_i,
    input wire logic [1:0] port_routing_sel_i,
    // Serial link pins
    input wire logic pcm_bit_clk_i,
    input wire logic pcm_frame_sync_i,
    input wire logic adpcm_bit_clk_i,
    input wire logic adpcm_frame_sync_i,
    input wire logic echo_port_ser_in_i,
    input wire logic secondary_port_ser_in_i,
    output logic echo_port_ser_out_o,
    output logic echo_port_ser_oe_o,
    output logic secondary_port_ser_out_o,
    output logic secondary_port_ser_oe_o,
    // Core side words
    input wire logic [WORD_BITS-1:0] echo_tx_line_i,
    input wire logic [WORD_BITS-1:0] echo_tx_acoustic_i,
    input wire logic [WORD_BITS-1:0] secondary_tx_i,
    output logic [WORD_BITS-1:0] echo_rx_word_o,
    output logic echo_rx_valid_o,
    output logic [WORD_BITS-1:0] secondary_rx_word_o,
    output logic secondary_rx_valid_o,
    // Mode state for the core
    output logic powered_down_o,
    output logic through_active_o,
    output logic [1:0] port_routing_o,
    output logic clk_range_o
);

    // Pin synchroniser stages
    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;
    logic [PIN_COUNT-1:0] pins;

    // Control registers
    logic [DATA_W-1:0] ctrl0_reg;
    logic [DATA_W-1:0] ctrl1_reg;
    logic [DATA_W-1:0] ctrl3_reg;

    // Resolved mode
    logic reset_pd_req;
    logic hold_req;
    logic init_mode;
    logic through_req;
    logic [1:0] routing_req;
    logic rpd_reg;
    logic hold_reg;
    logic init_reg;
    logic through_reg;
    logic [1:0] routing_reg;
    logic range_reg;
    logic block_rst;
    logic outputs_allowed;

    // Bit clock edge detection
    logic pbclk_prev_reg;
    logic abclk_prev_reg;
    logic pbclk_rise;
    logic pbclk_fall;
    logic abclk_rise;
    logic abclk_fall;

    // Secondary lane timing
    logic sec_rise;
    logic sec_fall;
    logic sec_sync;

    // Lane wiring
    logic [WORD_BITS-1:0] echo_tx_word;
    logic [THROUGH_BITS-1:0] echo_thru_nibble;
    logic [THROUGH_BITS-1:0] sec_thru_nibble;
    logic echo_out;
    logic echo_oe;
    logic sec_out;
    logic sec_oe;
    logic [WORD_BITS-1:0] echo_rx_word;
    logic [WORD_BITS-1:0] sec_rx_word;
    logic echo_rx_valid;
    logic sec_rx_valid;

    // Read data source
    logic [DATA_W-1:0] rd_mux;

    // Rising edge of a sampled level
    function automatic logic rose(input logic now, input logic prev);
        return now && !prev;
    endfunction

    // Falling edge of a sampled level
    function automatic logic fell(input logic now, input logic prev);
        return !now && prev;
    endfunction

    // All asynchronous pins in one vector
    assign pins = {secondary_port_ser_in_i, echo_port_ser_in_i,
                   adpcm_frame_sync_i, adpcm_bit_clk_i,
                   pcm_frame_sync_i, pcm_bit_clk_i,
                   port_routing_sel_i[1], port_routing_sel_i[0],
                   through_mode_sel_i, init_skip_i,
                   master_clk_range_sel_i,
                   powerdown_hold_in_n_i, reset_powerdown_in_n_i};

    // Two flops before any pin is read
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= PIN_RESET;
            pin_sync_reg <= PIN_RESET;
        end else begin
            pin_meta_reg <= pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Pins ORed with their register bits
    assign reset_pd_req = !pin_sync_reg[P_RPD_N]
                        || ctrl0_reg[CTRL0_RESET_PD_BIT];
    assign hold_req = !pin_sync_reg[P_HOLD_N]
                    || ctrl0_reg[CTRL0_PD_HOLD_BIT];
    assign through_req = pin_sync_reg[P_THRU]
                       || ctrl1_reg[CTRL1_THROUGH_BIT];
    assign routing_req = {pin_sync_reg[P_ROUTE1]
                          || ctrl3_reg[CTRL3_ROUTE_HI_BIT],
                          pin_sync_reg[P_ROUTE0]
                          || ctrl3_reg[CTRL3_ROUTE_LO_BIT]};
    assign init_mode = !(pin_sync_reg[P_SKIP] || ctrl0_reg[CTRL0_RUN_BIT]);

    // One registered mode for every consumer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rpd_reg <= 1'b0;
            hold_reg <= 1'b0;
            init_reg <= 1'b1;
            through_reg <= 1'b0;
            routing_reg <= 2'h0;
            range_reg <= 1'b0;
        end else begin
            rpd_reg <= reset_pd_req;
            hold_reg <= hold_req;
            init_reg <= init_mode;
            through_reg <= through_req;
            routing_reg <= routing_req;
            range_reg <= pin_sync_reg[P_RANGE];
        end
    end

    // Reset-powerdown clears registers and lanes
    assign block_rst = rst_i || rpd_reg;

    // Control registers; a hold request never touches them
    always_ff @(posedge core_clk_i) begin
        if (block_rst) begin
            ctrl0_reg <= CTRL_RESET;
            ctrl1_reg <= CTRL_RESET;
            ctrl3_reg <= CTRL_RESET;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                CTRL0_OFS: ctrl0_reg <= reg_wdata_i;
                CTRL1_OFS: ctrl1_reg <= reg_wdata_i;
                CTRL3_OFS: ctrl3_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr_i)
            CTRL0_OFS: rd_mux = ctrl0_reg;
            CTRL1_OFS: rd_mux = ctrl1_reg;
            CTRL3_OFS: rd_mux = ctrl3_reg;
            STATUS_OFS: begin
                rd_mux[ST_RESET_PD_BIT] = rpd_reg;
                rd_mux[ST_PD_HOLD_BIT] = hold_reg;
                rd_mux[ST_INIT_BIT] = init_reg;
                rd_mux[ST_THROUGH_BIT] = through_reg;
                rd_mux[ST_ROUTE_LO_BIT] = routing_reg[0];
                rd_mux[ST_ROUTE_HI_BIT] = routing_reg[1];
                rd_mux[ST_RANGE_BIT] = range_reg;
            end
            default: rd_mux = '0;
        endcase
    end

    // Read data stand one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // Last bit clock levels
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pbclk_prev_reg <= 1'b0;
            abclk_prev_reg <= 1'b0;
        end else begin
            pbclk_prev_reg <= pin_sync_reg[P_PBCLK];
            abclk_prev_reg <= pin_sync_reg[P_ABCLK];
        end
    end

    // Bit clock edges in the core domain
    assign pbclk_rise = rose(pin_sync_reg[P_PBCLK], pbclk_prev_reg);
    assign pbclk_fall = fell(pin_sync_reg[P_PBCLK], pbclk_prev_reg);
    assign abclk_rise = rose(pin_sync_reg[P_ABCLK], abclk_prev_reg);
    assign abclk_fall = fell(pin_sync_reg[P_ABCLK], abclk_prev_reg);

    // Routing bit 1: secondary pair on ADPCM timing
    assign sec_rise = routing_reg[1] ? abclk_rise : pbclk_rise;
    assign sec_fall = routing_reg[1] ? abclk_fall : pbclk_fall;
    assign sec_sync = routing_reg[1] ? pin_sync_reg[P_ASYNC]
                                     : pin_sync_reg[P_PSYNC];

    // Routing bit 0 picks line or acoustic word
    assign echo_tx_word = routing_reg[0] ? echo_tx_acoustic_i
                                         : echo_tx_line_i;

    // Through nibbles: crossed when routing bit 0 set
    assign echo_thru_nibble = routing_reg[0]
        ? sec_rx_word[WORD_BITS-1 -: THROUGH_BITS]
        : echo_rx_word[WORD_BITS-1 -: THROUGH_BITS];
    assign sec_thru_nibble = routing_reg[0]
        ? echo_rx_word[WORD_BITS-1 -: THROUGH_BITS]
        : sec_rx_word[WORD_BITS-1 -: THROUGH_BITS];

    // Echo pair, always on PCM timing
    pcm_serial_lane #(
        .WORD_LEN(WORD_BITS),
        .THRU_LEN(THROUGH_BITS)
    ) echo_lane (
        .core_clk_i(core_clk_i),
        .rst_i(block_rst),
        .bclk_rise_i(pbclk_rise),
        .bclk_fall_i(pbclk_fall),
        .sync_i(pin_sync_reg[P_PSYNC]),
        .ser_in_i(pin_sync_reg[P_ECHO_IN]),
        .hold_i(hold_reg),
        .through_i(through_reg),
        .tx_word_i(echo_tx_word),
        .thru_nibble_i(echo_thru_nibble),
        .ser_out_o(echo_out),
        .ser_oe_o(echo_oe),
        .rx_word_o(echo_rx_word),
        .rx_valid_o(echo_rx_valid)
    );

    // Secondary pair, timing per routing
    pcm_serial_lane #(
        .WORD_LEN(WORD_BITS),
        .THRU_LEN(THROUGH_BITS)
    ) secondary_lane (
        .core_clk_i(core_clk_i),
        .rst_i(block_rst),
        .bclk_rise_i(sec_rise),
        .bclk_fall_i(sec_fall),
        .sync_i(sec_sync),
        .ser_in_i(pin_sync_reg[P_SEC_IN]),
        .hold_i(hold_reg),
        .through_i(through_reg),
        .tx_word_i(secondary_tx_i),
        .thru_nibble_i(sec_thru_nibble),
        .ser_out_o(sec_out),
        .ser_oe_o(sec_oe),
        .rx_word_o(sec_rx_word),
        .rx_valid_o(sec_rx_valid)
    );

    // Outputs float in power-down and in the initial mode
    assign outputs_allowed = !rpd_reg && !hold_reg && !init_reg;

    // Serial pins; enable gated so power-down floats at once
    assign echo_port_ser_out_o = echo_out;
    assign echo_port_ser_oe_o = echo_oe && outputs_allowed;
    assign secondary_port_ser_out_o = sec_out;
    assign secondary_port_ser_oe_o = sec_oe && outputs_allowed;

    // Words to the core; no valid while floating
    assign echo_rx_word_o = echo_rx_word;
    assign echo_rx_valid_o = echo_rx_valid && outputs_allowed;
    assign secondary_rx_word_o = sec_rx_word;
    assign secondary_rx_valid_o = sec_rx_valid && outputs_allowed;

    // Mode state to the core
    assign powered_down_o = rpd_reg || hold_reg;
    assign through_active_o = through_reg;
    assign port_routing_o = routing_reg;
    assign clk_range_o = range_reg;
endmodule
`default_nettype wire

// ### verif/pcm_port_props.sv
// Purpose: Port checks.
// Assumes: Bit period near 15.6 core clocks.
// Notes: Slot lengths allow up to four clocks of jitter.
`timescale 1ns/100ps
`default_nettype none
module pcm_port_props
    import pcm_port_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic reset_powerdown_in_n_i,
    input wire logic powerdown_hold_in_n_i,
    input wire logic master_clk_range_sel_i,
    input wire logic through_mode_sel_i,
    input wire logic [1:0] port_routing_sel_i,
    input wire logic echo_port_ser_oe_o,
    input wire logic secondary_port_ser_oe_o,
    input wire logic echo_rx_valid_o,
    input wire logic powered_down_o,
    input wire logic through_active_o,
    input wire logic [1:0] port_routing_o,
    input wire logic clk_range_o
);
    logic [7:0] oe_cnt;
    logic clean;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Window length; a disturbed window is not judged
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !echo_port_ser_oe_o) begin
            oe_cnt <= 8'h00;
        end else begin
            oe_cnt <= oe_cnt + 8'h01;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i || powered_down_o || reg_wr_i) begin
            clean <= 1'b0;
        end else if (!echo_port_ser_oe_o && oe_cnt != 8'h00) begin
            clean <= 1'b1;
        end
    end
    // Pin held past the synchroniser
    sequence s_rpd_low; !reset_powerdown_in_n_i [*5]; endsequence
    sequence s_hold_low; !powerdown_hold_in_n_i [*5]; endsequence
    quiet_reset_a: assert property (disable iff (1'b0) rst_i |=>
        !echo_port_ser_oe_o && !secondary_port_ser_oe_o)
        else $error("driven after reset");
    pd_quiet_a: assert property (powered_down_o && $past(powered_down_o)
        |-> !echo_port_ser_oe_o && !secondary_port_ser_oe_o)
        else $error("driven in power-down");
    rpd_enter_a: assert property (s_rpd_low |-> powered_down_o)
        else $error("no reset power-down");
    hold_enter_a: assert property (s_hold_low |-> powered_down_o)
        else $error("no hold power-down");
    slot_len_a: assert property ($fell(echo_port_ser_oe_o) && clean
        && !powered_down_o |-> oe_cnt inside {[8'h3B:8'h41], [8'h79:8'h81]})
        else $error("bad drive window");
    valid_pulse_a: assert property (echo_rx_valid_o |=> !echo_rx_valid_o)
        else $error("valid too long");
    range_pin_a: assert property (master_clk_range_sel_i [*4]
        |-> clk_range_o) else $error("range ignored");
    route_or_a: assert property (port_routing_sel_i[1] [*5]
        |-> port_routing_o[1]) else $error("routing pin ignored");
    through_pin_a: assert property (through_mode_sel_i [*5]
        |-> through_active_o) else $error("through pin ignored");
    rdata_idle_a: assert property (!$past(reg_rd_i)
        |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
endmodule
bind pcm_serial_port_power_ctrl pcm_port_props i_pcm_port_props (.*);
`default_nettype wire

// ### verif/pcm_highway_model.sv
// Purpose: PCM highway partner model.
// Assumes: Free-running bit clock.
// Notes: Short frames keep runs short.
`timescale 1ns/100ps
`default_nettype none
module pcm_highway_model #(
    parameter int FRAME_BITS = 12
) (
    input wire logic adpcm_en_i,
    input wire logic [7:0] echo_word_i,
    input wire logic [7:0] sec_word_i,
    input wire logic echo_out_i,
    input wire logic echo_oe_i,
    input wire logic sec_out_i,
    input wire logic sec_oe_i,
    output logic bclk_o,
    output logic sync_o,
    output logic adpcm_sync_o,
    output logic echo_ser_o,
    output logic sec_ser_o,
    output logic [7:0] echo_cap_o,
    output logic [7:0] sec_cap_o,
    output logic [3:0] echo_n_o,
    output logic [3:0] sec_n_o,
    output int frames_o
);
    int k = FRAME_BITS - 1;
    logic [7:0] ecap = 8'h00, scap = 8'h00;
    logic [3:0] en = 4'h0, sn = 4'h0;
    // Odd phase, unrelated to the core clock
    initial begin
        {sync_o, adpcm_sync_o, echo_cap_o, sec_cap_o} = 18'h00000;
        {echo_n_o, sec_n_o, echo_ser_o, sec_ser_o} = 10'h003;
        frames_o = 0;
        bclk_o = 1'b0;
        #3.3;
        forever #62.5 bclk_o = ~bclk_o;
    end
    // Data on the rise; idle input pulled high
    always @(posedge bclk_o) begin
        k = (k + 1) % FRAME_BITS;
        echo_ser_o <= (k < 8) ? echo_word_i[7-k] : 1'b1;
        sec_ser_o <= (k < 8) ? sec_word_i[7-k] : 1'b1;
        if (k == 0) begin
            {echo_cap_o, sec_cap_o, echo_n_o, sec_n_o} <= {ecap, scap, en, sn};
            frames_o <= frames_o + 1;
            {ecap, scap, en, sn} = 24'h000000;
        end
    end
    // Sync leads the first rise by half a bit
    always @(negedge bclk_o) begin
        sync_o <= (k == FRAME_BITS - 1);
        adpcm_sync_o <= (k == FRAME_BITS - 1) && adpcm_en_i;
        if (echo_oe_i) begin
            ecap = {ecap[6:0], echo_out_i};
            en = en + 4'h1;
        end
        if (sec_oe_i) begin
            scap = {scap[6:0], sec_out_i};
            sn = sn + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/pcm_serial_port_power_ctrl_tb.sv
// Purpose: Self-checking bench.
// Assumes: 12-bit frames, 125 ns bit clock.
// Notes: ADPCM clock is the PCM bit clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module pcm_serial_port_power_ctrl_tb
    import pcm_port_pkg::*;
;
    logic core_clk_i, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic reset_powerdown_in_n_i = 1'b1, powerdown_hold_in_n_i = 1'b1;
    logic master_clk_range_sel_i = 1'b0, init_skip_i = 1'b0;
    logic through_mode_sel_i = 1'b0, adpcm_en = 1'b0;
    logic [1:0] port_routing_sel_i = 2'h0, port_routing_o;
    logic pcm_bit_clk_i, pcm_frame_sync_i, adpcm_bit_clk_i;
    logic adpcm_frame_sync_i, echo_port_ser_in_i, secondary_port_ser_in_i;
    logic echo_port_ser_out_o, echo_port_ser_oe_o;
    logic secondary_port_ser_out_o, secondary_port_ser_oe_o;
    logic [7:0] echo_tx_line_i = 8'h96, echo_tx_acoustic_i = 8'hC3;
    logic [7:0] secondary_tx_i = 8'h5A, echo_cap, sec_cap;
    logic [7:0] echo_rx_word_o, secondary_rx_word_o;
    logic [3:0] echo_n, sec_n;
    logic echo_rx_valid_o, secondary_rx_valid_o;
    logic powered_down_o, through_active_o, clk_range_o;
    int frames, n_mismatch = 0, comparisons = 0;
    assign adpcm_bit_clk_i = pcm_bit_clk_i;
    pcm_serial_port_power_ctrl i_pcm_serial_port_power_ctrl (.*);
    pcm_highway_model i_pcm_highway_model (
        .adpcm_en_i(adpcm_en), .echo_word_i(8'hA5), .sec_word_i(8'h3C),
        .echo_out_i(echo_port_ser_out_o), .echo_oe_i(echo_port_ser_oe_o),
        .sec_out_i(secondary_port_ser_out_o),
        .sec_oe_i(secondary_port_ser_oe_o), .bclk_o(pcm_bit_clk_i),
        .sync_o(pcm_frame_sync_i), .adpcm_sync_o(adpcm_frame_sync_i),
        .echo_ser_o(echo_port_ser_in_i), .sec_ser_o(secondary_port_ser_in_i),
        .echo_cap_o(echo_cap), .sec_cap_o(sec_cap), .echo_n_o(echo_n),
        .sec_n_o(sec_n), .frames_o(frames));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic print_verdict();
        $display("Counts: %0d checks, %0d failed", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask
    // Bounded wait; a stuck link ends the run
    task automatic wait_frames(input int n);
        int f0 = frames;
        int t = 0;
        while (frames < f0 + n && t < 400 * n) begin
            @(posedge core_clk_i);
            t++;
        end
        if (t >= 400 * n) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic t_reset();
        rd_chk(CTRL0_OFS, CTRL_RESET);
        rd_chk(CTRL3_OFS, CTRL_RESET);
        rd_chk(4'hF, 8'h00);
        master_clk_range_sel_i <= 1'b1;
        wait_frames(2);
        rd_chk(STATUS_OFS, 8'h44);
        `CHK(echo_n, 4'h0)
        master_clk_range_sel_i <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_normal_route();
        wr(CTRL0_OFS, 8'h01);
        wait_frames(3);
        `CHK(echo_cap, 8'h96)
        `CHK(echo_n, 4'h8)
        `CHK(sec_cap, 8'h5A)
        `CHK(echo_rx_word_o, 8'hA5)
        `CHK(secondary_rx_word_o, 8'h3C)
        wr(CTRL3_OFS, 8'h20);
        wait_frames(3);
        `CHK(echo_cap, 8'hC3)
        rd_chk(STATUS_OFS, 8'h10);
        wr(CTRL3_OFS, 8'h00);
        port_routing_sel_i <= 2'h2;
        wait_frames(3);
        `CHK(sec_n, 4'h0)
        `CHK(echo_n, 4'h8)
        adpcm_en <= 1'b1;
        wait_frames(3);
        `CHK(sec_cap, 8'h5A)
        port_routing_sel_i <= 2'h0;
        $display("test routing done");
    endtask
    task automatic t_through();
        through_mode_sel_i <= 1'b1;
        wait_frames(4);
        `CHK(echo_cap, 8'h0A)
        `CHK(echo_n, 4'h4)
        `CHK(sec_cap, 8'h03)
        `CHK(echo_rx_word_o, 8'hA0)
        `CHK(through_active_o, 1'b1)
        wr(CTRL3_OFS, 8'h20);
        wait_frames(4);
        `CHK(echo_cap, 8'h03)
        `CHK(sec_cap, 8'h0A)
        wr(CTRL3_OFS, 8'h00);
        through_mode_sel_i <= 1'b0;
        $display("test through done");
    endtask
    // Software reset pulse sent while held clears control 3
    task automatic t_power();
        wr(CTRL3_OFS, 8'h20);
        powerdown_hold_in_n_i <= 1'b0;
        wait_frames(2);
        `CHK(echo_n, 4'h0)
        `CHK(powered_down_o, 1'b1)
        rd_chk(CTRL3_OFS, 8'h20);
        wr(CTRL0_OFS, 8'h20);
        @(posedge core_clk_i);
        rd_chk(CTRL3_OFS, 8'h00);
        powerdown_hold_in_n_i <= 1'b1;
        wr(CTRL0_OFS, 8'h41);
        wait_frames(2);
        `CHK(echo_n, 4'h0)
        rd_chk(STATUS_OFS, 8'h02);
        wr(CTRL0_OFS, 8'h01);
        reset_powerdown_in_n_i <= 1'b0;
        wait_frames(2);
        `CHK(echo_n, 4'h0)
        `CHK(powered_down_o, 1'b1)
        reset_powerdown_in_n_i <= 1'b1;
        wait_frames(1);
        rd_chk(CTRL0_OFS, 8'h00);
        $display("test power done");
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_normal_route();
        t_through();
        t_power();
        print_verdict();
    end
endmodule
`default_nettype wire
